// ===== tpw_regs.vh
`ifndef TPW_REGS_VH
`define TPW_REGS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TPW_OFS_MAIN_CTL 8'h00
`define TPW_OFS_CNT_HI 8'h04
`define TPW_OFS_CNT_LO 8'h08
`define TPW_OFS_MOD_HI 8'h0C
`define TPW_OFS_MOD_LO 8'h10
`define TPW_CH_BASE_IDX 4'h2
`define TPW_CH_SUB_CTL 2'h0
`define TPW_CH_SUB_VHI 2'h1
`define TPW_CH_SUB_VLO 2'h2
// ----------------------------------------
// Field positions
// ----------------------------------------
`define TPW_FLAG_BIT 7
`define TPW_IRQEN_BIT 6
`define TPW_CENTER_BIT 5
`define TPW_CLKSEL_HI 4
`define TPW_CLKSEL_LO 3
`define TPW_PS_HI 2
`define TPW_PS_LO 0
`define TPW_MODE_HI 5
`define TPW_MODE_LO 4
`define TPW_EDGE_HI 3
`define TPW_EDGE_LO 2
// ----------------------------------------
// Reset values and encodings
// ----------------------------------------
`define TPW_RST_BYTE 8'h00
`define TPW_RST_WORD 16'h0000
`define TPW_CNT_FULL 16'hFFFF
`define TPW_MODE_CAPTURE 2'h0
`define TPW_MODE_COMPARE 2'h1
`define TPW_ACT_TOGGLE 2'h1
`define TPW_ACT_CLEAR 2'h2
`define TPW_ACT_SET 2'h3
`define TPW_PS_WIDTH 7
`endif

// ===== tpw_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for pin inputs; only the second stage leaves.
module tpw_sync #(
  parameter W = 1
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;
endmodule // tpw_sync

// ===== tpw_channel.v
`timescale 1ns/1ps
`include "tpw_regs.vh"
module tpw_channel (
  input wire hclk,
  input wire hresetn,
  input wire center_mode,
  input wire [15:0] cnt,
  input wire cnt_upd,
  input wire cnt_down,
  input wire rev_evt,
  input wire wr_ctl,
  input wire wr_vhi,
  input wire wr_vlo,
  input wire rd_ctl,
  input wire [7:0] wdata,
  input wire pin_sync,
  output wire [7:0] ctl_rd,
  output wire [15:0] val_rd,
  output reg pin_out_ff,
  output reg pin_oe_ff,
  output reg irq_ff
);
  reg [6:0] ctl_ff;
  reg flag_ff;
  reg armed_ff;
  reg [7:0] buf_hi_ff;
  reg [7:0] buf_lo_ff;
  reg got_hi_ff;
  reg got_lo_ff;
  reg [15:0] val_ff;
  reg pin_prev_ff;
  reg nxt_pin;
  wire [1:0] mode = ctl_ff[`TPW_MODE_HI:`TPW_MODE_LO];
  wire [1:0] edge_sel = ctl_ff[`TPW_EDGE_HI:`TPW_EDGE_LO];
  wire pol = ctl_ff[`TPW_EDGE_LO];
  wire is_cap = !center_mode && mode == `TPW_MODE_CAPTURE;
  wire is_cmp = !center_mode && mode == `TPW_MODE_COMPARE;
  wire is_epwm = !center_mode && mode[1];
  wire match = cnt_upd && cnt == val_ff;
  wire rise = pin_sync && !pin_prev_ff;
  wire fall = !pin_sync && pin_prev_ff;
  wire cap_evt = is_cap && ((edge_sel[0] && rise) || (edge_sel[1] && fall));
  wire evt = cap_evt || (!is_cap && match);
  wire both = got_hi_ff && got_lo_ff;
  // Compare channels load at once; PWM loads wait for the period boundary.
  wire load = both && !is_cap && (is_cmp || (is_epwm && cnt == `TPW_RST_WORD) || rev_evt);
  wire cpwm_ok = val_ff != `TPW_RST_WORD && !val_ff[15];
  wire cpwm_hi = cpwm_ok && (cnt < val_ff || (cnt == val_ff && cnt_down));

  always @* begin
    nxt_pin = pin_out_ff;
    if (center_mode) begin
      nxt_pin = cpwm_hi ^ pol;
    end else if (is_epwm) begin
      nxt_pin = (cnt < val_ff) ^ pol;
    end else if (is_cmp && match) begin
      case (edge_sel)
        `TPW_ACT_TOGGLE: nxt_pin = !pin_out_ff;
        `TPW_ACT_CLEAR: nxt_pin = 1'b0;
        `TPW_ACT_SET: nxt_pin = 1'b1;
        default: nxt_pin = pin_out_ff;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_ff <= 7'h00;
      flag_ff <= 1'b0;
      armed_ff <= 1'b0;
      buf_hi_ff <= `TPW_RST_BYTE;
      buf_lo_ff <= `TPW_RST_BYTE;
      got_hi_ff <= 1'b0;
      got_lo_ff <= 1'b0;
      val_ff <= `TPW_RST_WORD;
      pin_prev_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      pin_prev_ff <= pin_sync;
      pin_out_ff <= nxt_pin;
      pin_oe_ff <= center_mode || (!is_cap && edge_sel != 2'h0);
      irq_ff <= flag_ff && ctl_ff[`TPW_IRQEN_BIT];
      if (wr_ctl) ctl_ff <= wdata[6:0];
      // A new event always wins and restarts the clearing sequence.
      if (evt) begin
        flag_ff <= 1'b1;
        armed_ff <= 1'b0;
      end else if (rd_ctl && flag_ff) begin
        armed_ff <= 1'b1;
      end else if (wr_ctl && !wdata[`TPW_FLAG_BIT] && armed_ff) begin
        flag_ff <= 1'b0;
        armed_ff <= 1'b0;
      end
      if (wr_ctl || load) begin
        got_hi_ff <= 1'b0;
        got_lo_ff <= 1'b0;
      end else begin
        if (wr_vhi) got_hi_ff <= 1'b1;
        if (wr_vlo) got_lo_ff <= 1'b1;
      end
      if (wr_vhi) buf_hi_ff <= wdata;
      if (wr_vlo) buf_lo_ff <= wdata;
      if (cap_evt) val_ff <= cnt;
      else if (load && !wr_ctl) val_ff <= {buf_hi_ff, buf_lo_ff};
    end
  end

  assign ctl_rd = {flag_ff, ctl_ff};
  assign val_rd = val_ff;
endmodule // tpw_channel

// ===== tpw_top.v
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "tpw_regs.vh"
module tpw_top #(
  parameter CHANNELS = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout_ff,
  output reg hresp_ff,
  output reg [31:0] hrdata_ff,
  input wire [CHANNELS-1:0] ch_pin_in,
  output wire [CHANNELS-1:0] ch_pin_out,
  output wire [CHANNELS-1:0] ch_pin_oe,
  output wire [CHANNELS-1:0] ch_irq,
  output reg ovf_irq_ff
);

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  // Every access finishes with no wait state, so the data phase of a write
  // never overlaps an address phase of the single-transfer master.
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  wire addr_ok = hsel && htrans[1] && hready;
  wire rd_req = addr_ok && !hwrite;
  wire [7:0] rd_addr = haddr[7:0];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok) wr_addr_ff <= haddr[7:0];
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
    end
  end

  wire [7:0] wbyte = hwdata[7:0];
  wire wr_main = wr_pend_ff && wr_addr_ff == `TPW_OFS_MAIN_CTL;
  wire wr_cnt = wr_pend_ff && (wr_addr_ff == `TPW_OFS_CNT_HI || wr_addr_ff == `TPW_OFS_CNT_LO);
  wire wr_mhi = wr_pend_ff && wr_addr_ff == `TPW_OFS_MOD_HI;
  wire wr_mlo = wr_pend_ff && wr_addr_ff == `TPW_OFS_MOD_LO;
  wire rd_main = rd_req && rd_addr == `TPW_OFS_MAIN_CTL;

  // ----------------------------------------
  // Main control and prescaler
  // ----------------------------------------
  reg [6:0] main_ff;
  reg [`TPW_PS_WIDTH-1:0] presc_ff;
  wire center = main_ff[`TPW_CENTER_BIT];
  wire clk_on = main_ff[`TPW_CLKSEL_HI:`TPW_CLKSEL_LO] != 2'h0;
  wire [2:0] ps = main_ff[`TPW_PS_HI:`TPW_PS_LO];
  wire [`TPW_PS_WIDTH-1:0] ps_mask = ~({`TPW_PS_WIDTH{1'b1}} << ps);
  wire tick = clk_on && (presc_ff & ps_mask) == ps_mask;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_ff <= {`TPW_PS_WIDTH{1'b0}};
    end else if (!clk_on || wr_cnt) begin
      presc_ff <= {`TPW_PS_WIDTH{1'b0}};
    end else begin
      presc_ff <= presc_ff + 1'b1;
    end
  end

  // ----------------------------------------
  // Modulus buffering
  // ----------------------------------------
  reg [15:0] mod_ff;
  reg [7:0] mbuf_hi_ff;
  reg [7:0] mbuf_lo_ff;
  reg mgot_hi_ff;
  reg mgot_lo_ff;
  reg rev_ff;
  wire mboth = mgot_hi_ff && mgot_lo_ff;
  // In up mode the new modulus takes hold as soon as both bytes are in.
  wire mload = mboth && (!center || rev_ff);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_ff <= `TPW_RST_WORD;
      mbuf_hi_ff <= `TPW_RST_BYTE;
      mbuf_lo_ff <= `TPW_RST_BYTE;
      mgot_hi_ff <= 1'b0;
      mgot_lo_ff <= 1'b0;
    end else begin
      if (wr_mhi) mbuf_hi_ff <= wbyte;
      if (wr_mlo) mbuf_lo_ff <= wbyte;
      if (wr_main || mload) begin
        mgot_hi_ff <= 1'b0;
        mgot_lo_ff <= 1'b0;
      end else begin
        if (wr_mhi) mgot_hi_ff <= 1'b1;
        if (wr_mlo) mgot_lo_ff <= 1'b1;
      end
      if (mload && !wr_main) mod_ff <= {mbuf_hi_ff, mbuf_lo_ff};
    end
  end

  // ----------------------------------------
  // Main counter
  // ----------------------------------------
  reg [15:0] cnt_ff;
  reg down_ff;
  reg upd_ff;
  reg [15:0] nxt_cnt;
  reg nxt_down;
  reg nxt_wrap;
  reg nxt_rev;
  // A zero modulus means the full 16-bit range in up mode.
  wire [15:0] term = (mod_ff == `TPW_RST_WORD) ? `TPW_CNT_FULL : mod_ff;

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_down = down_ff;
    nxt_wrap = 1'b0;
    nxt_rev = 1'b0;
    if (!center) begin
      nxt_down = 1'b0;
      if (cnt_ff == term) begin
        nxt_cnt = `TPW_RST_WORD;
        nxt_wrap = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end else if (!down_ff) begin
      // With a zero modulus the counter never finds a turning point; that
      // setting is left to software to avoid.
      if (cnt_ff == mod_ff && mod_ff != `TPW_RST_WORD) begin
        nxt_cnt = cnt_ff - 16'h0001;
        nxt_down = 1'b1;
        nxt_rev = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end else begin
      if (cnt_ff == `TPW_RST_WORD) begin
        nxt_cnt = 16'h0001;
        nxt_down = 1'b0;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  wire ovf_evt = tick && (nxt_wrap || nxt_rev);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff <= `TPW_RST_WORD;
      down_ff <= 1'b0;
      upd_ff <= 1'b0;
      rev_ff <= 1'b0;
    end else if (wr_cnt) begin
      cnt_ff <= `TPW_RST_WORD;
      down_ff <= 1'b0;
      upd_ff <= 1'b0;
      rev_ff <= 1'b0;
    end else begin
      if (tick) cnt_ff <= nxt_cnt;
      if (tick) down_ff <= nxt_down;
      upd_ff <= tick;
      rev_ff <= tick && nxt_rev;
    end
  end

  // ----------------------------------------
  // Main control register and overflow flag
  // ----------------------------------------
  reg ovf_flag_ff;
  reg ovf_armed_ff;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_ff <= 7'h00;
      ovf_flag_ff <= 1'b0;
      ovf_armed_ff <= 1'b0;
      ovf_irq_ff <= 1'b0;
    end else begin
      if (wr_main) main_ff <= wbyte[6:0];
      // The event takes priority over a clear in the same cycle.
      if (ovf_evt) begin
        ovf_flag_ff <= 1'b1;
        ovf_armed_ff <= 1'b0;
      end else if (rd_main && ovf_flag_ff) begin
        ovf_armed_ff <= 1'b1;
      end else if (wr_main && !wbyte[`TPW_FLAG_BIT] && ovf_armed_ff) begin
        ovf_flag_ff <= 1'b0;
        ovf_armed_ff <= 1'b0;
      end
      ovf_irq_ff <= ovf_flag_ff && main_ff[`TPW_IRQEN_BIT];
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  wire [CHANNELS-1:0] pin_sync;
  wire [8*CHANNELS-1:0] ch_ctl_rd;
  wire [16*CHANNELS-1:0] ch_val_rd;

  tpw_sync #(
    .W(CHANNELS)
  ) u_pin_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(ch_pin_in),
    .dout(pin_sync)
  );

  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
      localparam integer CH_IDX = `TPW_CH_BASE_IDX + gi;
      wire [3:0] ch_idx = CH_IDX[3:0];
      wire wsel = wr_pend_ff && wr_addr_ff[7:4] == ch_idx;
      wire rsel = rd_req && rd_addr[7:4] == ch_idx;
      tpw_channel u_ch (
        .hclk(hclk),
        .hresetn(hresetn),
        .center_mode(center),
        .cnt(cnt_ff),
        .cnt_upd(upd_ff),
        .cnt_down(down_ff),
        .rev_evt(rev_ff),
        .wr_ctl(wsel && wr_addr_ff[3:2] == `TPW_CH_SUB_CTL),
        .wr_vhi(wsel && wr_addr_ff[3:2] == `TPW_CH_SUB_VHI),
        .wr_vlo(wsel && wr_addr_ff[3:2] == `TPW_CH_SUB_VLO),
        .rd_ctl(rsel && rd_addr[3:2] == `TPW_CH_SUB_CTL),
        .wdata(wbyte),
        .pin_sync(pin_sync[gi]),
        .ctl_rd(ch_ctl_rd[8*gi +: 8]),
        .val_rd(ch_val_rd[16*gi +: 16]),
        .pin_out_ff(ch_pin_out[gi]),
        .pin_oe_ff(ch_pin_oe[gi]),
        .irq_ff(ch_irq[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Reads return the live counter; the two-byte read latch is not modelled.
  reg [7:0] rd_byte;
  integer ci;

  always @* begin
    rd_byte = 8'h00;
    case (rd_addr)
      `TPW_OFS_MAIN_CTL: rd_byte = {ovf_flag_ff, main_ff};
      `TPW_OFS_CNT_HI: rd_byte = cnt_ff[15:8];
      `TPW_OFS_CNT_LO: rd_byte = cnt_ff[7:0];
      `TPW_OFS_MOD_HI: rd_byte = mod_ff[15:8];
      `TPW_OFS_MOD_LO: rd_byte = mod_ff[7:0];
      default: rd_byte = 8'h00;
    endcase
    for (ci = 0; ci < CHANNELS; ci = ci + 1) begin
      if (rd_addr[7:4] == `TPW_CH_BASE_IDX + ci[3:0]) begin
        case (rd_addr[3:0])
          {`TPW_CH_SUB_CTL, 2'h0}: rd_byte = ch_ctl_rd[8*ci +: 8];
          {`TPW_CH_SUB_VHI, 2'h0}: rd_byte = ch_val_rd[16*ci+8 +: 8];
          {`TPW_CH_SUB_VLO, 2'h0}: rd_byte = ch_val_rd[16*ci +: 8];
          default: rd_byte = 8'h00;
        endcase
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h00000000;
    end else if (rd_req) begin
      hrdata_ff <= {24'h000000, rd_byte};
    end
  end

endmodule // tpw_top

// ===== tpw_top_asserts.sv
`timescale 1ns/1ps
module tpw_chk #(
  parameter CHANNELS = 2
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout_ff,
  input wire hresp_ff,
  input wire [31:0] hrdata_ff,
  input wire [CHANNELS-1:0] ch_pin_oe,
  input wire [CHANNELS-1:0] ch_irq,
  input wire ovf_irq_ff
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ------------------------------------
  // Write age
  // ------------------------------------
  // Flags and enables only drop through a register write, so any falling
  // request or moving enable must sit a few cycles behind one.
  reg [3:0] wr_age_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_age_ff <= 4'hF;
    end else if (hsel & htrans[1] & hready & hwrite) begin
      wr_age_ff <= 4'h0;
    end else if (wr_age_ff != 4'hF) begin
      wr_age_ff <= wr_age_ff + 4'h1;
    end
  end
  ready_always_a: assert property (hreadyout_ff)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp_ff)
    else $error("error response");
  rdata_upper_a: assert property (hrdata_ff[31:8] == 24'h000000)
    else $error("upper read bits set");
  rdata_hold_a: assert property (!$stable(hrdata_ff) |-> $past(hsel & htrans[1] & hready & !hwrite))
    else $error("read data moved without a read");
  irq0_drop_a: assert property ($fell(ch_irq[0]) |-> wr_age_ff <= 4'h4)
    else $error("channel 0 request dropped without a write");
  irq1_drop_a: assert property ($fell(ch_irq[1]) |-> wr_age_ff <= 4'h4)
    else $error("channel 1 request dropped without a write");
  ovf_drop_a: assert property ($fell(ovf_irq_ff) |-> wr_age_ff <= 4'h4)
    else $error("overflow request dropped without a write");
  oe_move_a: assert property (!$stable(ch_pin_oe) |-> wr_age_ff <= 4'h4)
    else $error("pin enable moved without a write");
endmodule // tpw_chk
bind tpw_top tpw_chk #(.CHANNELS(CHANNELS)) u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite,
  .hready, .hreadyout_ff, .hresp_ff, .hrdata_ff, .ch_pin_oe, .ch_irq, .ovf_irq_ff);

// ===== tpw_load.sv
`timescale 1ns/1ps
// ------------------------------------
// Load on the channel pins
// ------------------------------------
// Counts driven-high cycles; an undriven pin never counts as high.
module tpw_load (
  input wire hclk,
  input wire clr,
  input wire meas,
  input wire [1:0] kick,
  input wire [1:0] pin_out,
  input wire [1:0] pin_oe,
  output reg [1:0] pin_in_ff,
  output reg [31:0] hi0_ff,
  output reg [31:0] hi1_ff,
  output reg [31:0] rise0_ff
);
  reg last0_ff;
  initial begin
    pin_in_ff = 2'h0;
    last0_ff = 1'b0;
  end
  always @(posedge hclk) begin
    pin_in_ff <= kick;
    last0_ff <= pin_out[0] & pin_oe[0];
    if (clr) begin
      hi0_ff <= 32'h0;
      hi1_ff <= 32'h0;
      rise0_ff <= 32'h0;
    end else if (meas) begin
      hi0_ff <= hi0_ff + (pin_out[0] & pin_oe[0]);
      hi1_ff <= hi1_ff + (pin_out[1] & pin_oe[1]);
      rise0_ff <= rise0_ff + (pin_out[0] & pin_oe[0] & !last0_ff);
    end
  end
endmodule // tpw_load

// ===== timer_compare_pwm_channels_test.sv
`timescale 1ns/1ps
`include "tpw_regs.vh"
module timer_compare_pwm_channels_test;
  reg hclk;
  reg hresetn;
  reg hsel;
  reg hwrite;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [31:0] haddr;
  reg [31:0] hwdata;
  reg clr;
  reg meas;
  reg [1:0] kick;
  wire hready;
  wire hresp;
  wire ovf;
  wire [31:0] hrdata;
  wire [1:0] pin_out;
  wire [1:0] pin_oe;
  wire [1:0] irq;
  wire [1:0] pin_in;
  wire [31:0] hi0;
  wire [31:0] hi1;
  wire [31:0] rs0;
  integer fail_count;
  integer n_tests;
  integer m;
  integer e;
  integer i;
  reg [15:0] r;
  reg [15:0] v;
  reg [15:0] w;
  reg [15:0] old;
  reg [31:0] exp_q[$];
  reg [31:0] got_q[$];
  tpw_top #(.CHANNELS(2)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout_ff(hready), .hresp_ff(hresp), .hrdata_ff(hrdata), .ch_pin_in(pin_in),
    .ch_pin_out(pin_out), .ch_pin_oe(pin_oe), .ch_irq(irq), .ovf_irq_ff(ovf));
  tpw_load u_load (.hclk(hclk), .clr(clr), .meas(meas), .kick(kick), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_in_ff(pin_in), .hi0_ff(hi0), .hi1_ff(hi1), .rise0_ff(rs0));
  // ------------------------------------
  // Tasks
  // ------------------------------------
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  task wait_rdy;
    integer k;
    begin
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
        k = k + 1;
        if (k > 50) begin
          $display("MISMATCH t=%0t bus answer timed out", $time);
          fail_count = fail_count + 1;
          give_verdict;
        end
        @(posedge hclk);
      end
    end
  endtask
  task bus(input [7:0] a, input wr_n, input [7:0] d, output [7:0] q);
    begin
      haddr <= {24'h000000, a};
      hwrite <= wr_n;
      htrans <= 2'h2;
      hsel <= 1'b1;
      wait_rdy;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h000000, d};
      wait_rdy;
      q = hrdata[7:0];
    end
  endtask
  task note(input [31:0] x, input [31:0] g);
    begin
      exp_q.push_back(x);
      got_q.push_back(g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task rd(input [7:0] a, input [7:0] x);
    reg [7:0] q;
    begin
      bus(a, 1'b0, 8'h00, q);
      note({24'h000000, x}, {24'h000000, q});
    end
  endtask
  task setv(input [7:0] a, input [15:0] d);
    begin
      wr(a, d[15:8]);
      wr(a + 8'h04, d[7:0]);
    end
  endtask
  task measure(input integer n, input integer x0, input integer x1);
    begin
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      meas <= 1'b1;
      tick(n);
      meas <= 1'b0;
      tick(1);
      note(x0, hi0);
      note(x1, hi1);
    end
  endtask
  function integer cexp(input [15:0] d);
    cexp = (d[15] || d == 16'h0000) ? 0 : (d > m) ? 4 * m : 4 * d;
  endfunction
  // Results are compared in arrival order, apart from whoever produced them.
  always @(posedge hclk) begin
    while (got_q.size() > 0) begin
      n_tests = n_tests + 1;
      if (got_q[0] !== exp_q[0]) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t exp %h got %h", $time, exp_q[0], got_q[0]);
      end
      got_q.pop_front();
      exp_q.pop_front();
    end
  end
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    {hresetn, hsel, hwrite, htrans, clr, meas, kick} = 9'h000;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    fail_count = 0;
    n_tests = 0;
    tick(6);
    hresetn <= 1'b1;
    tick(1);
    r = $urandom(43382);
    m = 48 + $urandom % 32;
    r = 1 + $urandom % (m - 1);
    rd(`TPW_OFS_MAIN_CTL, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h80, 8'h00);
    wr(8'h20, 8'h14);
    wr(8'h24, 8'h12);
    rd(8'h24, 8'h00);
    wr(8'h20, 8'h14);
    wr(8'h28, 8'h34);
    rd(8'h28, 8'h00);
    wr(8'h24, 8'h12);
    // The value moves from the buffer one cycle after the second byte lands.
    tick(1);
    rd(8'h28, 8'h34);
    wr(`TPW_OFS_MOD_HI, 8'h00);
    wr(`TPW_OFS_MAIN_CTL, 8'h00);
    wr(`TPW_OFS_MOD_LO, m[7:0]);
    rd(`TPW_OFS_MOD_LO, 8'h00);
    wr(`TPW_OFS_MOD_HI, 8'h00);
    tick(1);
    rd(`TPW_OFS_MOD_LO, m[7:0]);
    old = m >> 1;
    wr(8'h20, 8'h54);
    setv(8'h24, old);
    wr(`TPW_OFS_MAIN_CTL, 8'h48);
    tick(2 * (m + 1));
    measure(4 * (m + 1), 2 * (m + 1), 0);
    note(2, rs0);
    rd(8'h20, 8'hD4);
    note(1, irq[0]);
    note(1, ovf);
    // The second match lands between the arming read and the clearing write.
    tick(m + 2);
    wr(8'h20, 8'h54);
    rd(8'h20, 8'hD4);
    wr(`TPW_OFS_MAIN_CTL, 8'h40);
    rd(8'h20, 8'hD4);
    wr(8'h20, 8'h54);
    rd(8'h20, 8'h54);
    rd(`TPW_OFS_MAIN_CTL, 8'hC0);
    wr(`TPW_OFS_MAIN_CTL, 8'h40);
    rd(`TPW_OFS_MAIN_CTL, 8'h40);
    tick(2);
    note(0, irq[0]);
    note(0, ovf);
    wr(8'h30, 8'h04);
    rd(8'h30, 8'h04);
    kick <= 2'h2;
    tick(8);
    rd(8'h30, 8'h84);
    kick <= 2'h0;
    wr(`TPW_OFS_MAIN_CTL, 8'h08);
    wr(8'h20, 8'h28);
    wr(8'h30, 8'h2C);
    for (i = 0; i < 3; i = i + 1) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? r : m + 1;
      wr(`TPW_OFS_CNT_LO, 8'h00);
      setv(8'h24, v);
      setv(8'h34, v);
      rd(8'h28, old[7:0]);
      tick(m + 4);
      e = (v > m) ? m + 1 : v;
      measure(2 * (m + 1), 2 * e, 2 * (m + 1 - e));
      old = v;
    end
    wr(`TPW_OFS_MAIN_CTL, 8'h00);
    rd(`TPW_OFS_MAIN_CTL, 8'h80);
    wr(`TPW_OFS_MAIN_CTL, 8'h28);
    wr(`TPW_OFS_CNT_LO, 8'h00);
    wr(8'h30, 8'h18);
    for (i = 0; i < 3; i = i + 1) begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? r : m + 3;
      w = (i == 0) ? (16'h8000 | r) : (i == 1) ? m + 3 : r;
      setv(8'h24, v);
      setv(8'h34, w);
      tick(4 * m);
      measure(4 * m, cexp(v), cexp(w));
    end
    rd(`TPW_OFS_MAIN_CTL, 8'hA8);
    // A zero modulus at half-rate ticks lets the count pass 255 with no wrap.
    wr(`TPW_OFS_MAIN_CTL, 8'h09);
    setv(`TPW_OFS_MOD_HI, 16'h0000);
    wr(`TPW_OFS_CNT_LO, 8'h00);
    tick(600);
    rd(`TPW_OFS_CNT_HI, 8'h01);
    tick(2);
    give_verdict;
  end
endmodule // timer_compare_pwm_channels_test
